// >>> verilog/fsb_top.sv
// fsb_top: flash boot serial loader with flash power and access gate registers
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module fsb_top #(
	parameter int RAM_DEPTH = 1904,
	parameter int RAM_AW = 11
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register bus
	input wire fsb_pkg::fsb_avl_req_t avl_req,
	output logic [31:0] avl_readdata,
	output logic avl_waitrequest,
	// serial link
	input wire logic rxd,
	output logic txd_o,
	output logic txd_oe,
	// system
	input wire logic boot_mode,
	input wire logic wdt_overflow,
	input wire logic subactive,
	output logic flash_powerdown,
	output logic boot_active,
	output logic ram_reserved,
	output logic branch_pulse
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	fsb_pkg::fsb_state_t state_r;
	logic [15:0] wait_cnt_r;
	logic [15:0] low_cnt_r;
	logic low_sat_r;
	logic [15:0] rem_r;
	logic [15:0] quo_r;
	logic [15:0] bit_rate_setting_reg;
	logic [15:0] len_r;
	logic [15:0] load_cnt_r;
	logic receive_enable_bit;
	logic transmit_enable_bit;
	logic tx_pin_direction_bit;
	logic tx_pin_output_bit;
	logic flash_powerdown_inhibit;
	logic flash_ctrl_reg_access_enable;
	logic [RAM_AW-1:0] ram_raddr_r;
	logic [7:0] ram_rdata;
	logic waitreq_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_mux;
	logic wr_fire;
	logic rx_busy_r;
	logic [15:0] rx_cnt_r;
	logic [3:0] rx_bit_r;
	logic [7:0] rx_shift_r;
	logic rx_valid_r;
	logic rx_en;
	logic tx_go_r;
	logic tx_busy_r;
	logic [15:0] tx_cnt_r;
	logic [3:0] tx_bit_r;
	logic [9:0] tx_shift_r;
	logic pd_r;
	logic branch_r;
	logic boot_active_r;
	logic [15:0] len_nxt;

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avl_readdata = rdata_r;
	assign avl_waitrequest = waitreq_r;
	assign txd_o = tx_pin_output_bit;
	assign txd_oe = tx_pin_direction_bit;
	assign flash_powerdown = pd_r;
	assign boot_active = boot_active_r;
	assign branch_pulse = branch_r;

	// ----------------------------------------------------------------
	// register bus slave
	// ----------------------------------------------------------------
	// every access answers one cycle after it is seen
	assign wr_fire = avl_req.write && !waitreq_r;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avl_req.address)
			fsb_pkg::REG_PWR: begin
				if (flash_ctrl_reg_access_enable) begin
					rd_mux[fsb_pkg::PWR_INHIBIT_POS] = flash_powerdown_inhibit;
				end
			end
			fsb_pkg::REG_GATE: begin
				rd_mux[fsb_pkg::GATE_ENABLE_POS] = flash_ctrl_reg_access_enable;
			end
			fsb_pkg::REG_STAT: begin
				rd_mux[3:0] = state_r;
				rd_mux[4] = (state_r != fsb_pkg::ST_EXIT);
				rd_mux[5] = receive_enable_bit;
				rd_mux[6] = transmit_enable_bit;
				rd_mux[7] = tx_pin_direction_bit;
				rd_mux[8] = tx_pin_output_bit;
				rd_mux[9] = ram_reserved;
			end
			fsb_pkg::REG_BRR: rd_mux[15:0] = bit_rate_setting_reg;
			fsb_pkg::REG_CNT: rd_mux[15:0] = load_cnt_r;
			fsb_pkg::REG_RADDR: rd_mux[RAM_AW-1:0] = ram_raddr_r;
			fsb_pkg::REG_RDATA: rd_mux[7:0] = ram_rdata;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			waitreq_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			waitreq_r <= 1'b1;
			if ((avl_req.read || avl_req.write) && waitreq_r) begin
				waitreq_r <= 1'b0;
				if (avl_req.read) begin
					rdata_r <= rd_mux;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			flash_powerdown_inhibit <= fsb_pkg::RST_INHIBIT;
			flash_ctrl_reg_access_enable <= fsb_pkg::RST_ENABLE;
			ram_raddr_r <= '0;
		end else if (wr_fire) begin
			case (avl_req.address)
				fsb_pkg::REG_PWR: begin
					if (flash_ctrl_reg_access_enable) begin
						flash_powerdown_inhibit <= avl_req.writedata[fsb_pkg::PWR_INHIBIT_POS];
					end
				end
				fsb_pkg::REG_GATE: begin
					flash_ctrl_reg_access_enable <= avl_req.writedata[fsb_pkg::GATE_ENABLE_POS];
				end
				fsb_pkg::REG_RADDR: ram_raddr_r <= avl_req.writedata[RAM_AW-1:0];
				default: ram_raddr_r <= ram_raddr_r;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// flash power-down
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pd_r <= 1'b0;
		end else begin
			pd_r <= subactive && !flash_powerdown_inhibit;
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	assign rx_en = (state_r == fsb_pkg::ST_WAIT_55) || (state_r == fsb_pkg::ST_LEN_HI) ||
		(state_r == fsb_pkg::ST_LEN_LO) || (state_r == fsb_pkg::ST_LOAD);

	// start, eight data bits lsb first, one stop, no parity
	always_ff @(posedge clk_sys) begin
		if (!rst_b || !rx_en) begin
			rx_busy_r <= 1'b0;
			rx_valid_r <= 1'b0;
			rx_cnt_r <= 16'h0000;
			rx_bit_r <= 4'h0;
			rx_shift_r <= 8'h00;
		end else begin
			rx_valid_r <= 1'b0;
			if (!rx_busy_r) begin
				if (!rxd) begin
					rx_busy_r <= 1'b1;
					rx_cnt_r <= {1'b0, bit_rate_setting_reg[15:1]};
					rx_bit_r <= 4'h0;
				end
			end else if (rx_cnt_r != 16'h0000) begin
				rx_cnt_r <= rx_cnt_r - 16'h0001;
			end else begin
				rx_cnt_r <= bit_rate_setting_reg - 16'h0001;
				rx_bit_r <= rx_bit_r + 4'h1;
				if (rx_bit_r == 4'h0) begin
					// glitch rather than a start bit
					rx_busy_r <= !rxd;
				end else if (rx_bit_r <= 4'h8) begin
					rx_shift_r <= {rxd, rx_shift_r[7:1]};
				end else begin
					// framing error drops the byte
					rx_busy_r <= 1'b0;
					rx_valid_r <= rxd;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tx_busy_r <= 1'b0;
			tx_cnt_r <= 16'h0000;
			tx_bit_r <= 4'h0;
			tx_shift_r <= 10'h3FF;
		end else if (!tx_busy_r) begin
			if (tx_go_r) begin
				tx_busy_r <= 1'b1;
				tx_cnt_r <= bit_rate_setting_reg - 16'h0001;
				tx_bit_r <= 4'h0;
				// single zero byte, stop bit then idle high
				tx_shift_r <= {1'b1, fsb_pkg::SYNC_BYTE, 1'b0};
			end
		end else if (tx_cnt_r != 16'h0000) begin
			tx_cnt_r <= tx_cnt_r - 16'h0001;
		end else begin
			tx_cnt_r <= bit_rate_setting_reg - 16'h0001;
			tx_shift_r <= {1'b1, tx_shift_r[9:1]};
			tx_bit_r <= tx_bit_r + 4'h1;
			if (tx_bit_r == 4'h9) begin
				tx_busy_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin and serial control bits
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tx_pin_direction_bit <= 1'b0;
			tx_pin_output_bit <= 1'b1;
			receive_enable_bit <= 1'b0;
			transmit_enable_bit <= 1'b0;
		end else if (state_r == fsb_pkg::ST_RESET_WAIT) begin
			if (wait_cnt_r == 16'(fsb_pkg::BOOT_READY_CYC - 1) && boot_mode) begin
				tx_pin_direction_bit <= 1'b1;
				receive_enable_bit <= 1'b1;
				transmit_enable_bit <= 1'b1;
			end
		end else if (state_r == fsb_pkg::ST_BRANCH || wdt_overflow) begin
			receive_enable_bit <= 1'b0;
			transmit_enable_bit <= 1'b0;
			tx_pin_output_bit <= 1'b1;
		end else if (transmit_enable_bit) begin
			tx_pin_output_bit <= tx_busy_r ? tx_shift_r[0] : 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// boot sequencer
	// ----------------------------------------------------------------
	always_comb begin
		len_nxt = {len_r[15:8], rx_shift_r};
		if (len_nxt > fsb_pkg::AREA_SIZE || len_nxt > 16'(RAM_DEPTH)) begin
			len_nxt = (fsb_pkg::AREA_SIZE < 16'(RAM_DEPTH)) ? fsb_pkg::AREA_SIZE : 16'(RAM_DEPTH);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_r <= fsb_pkg::ST_RESET_WAIT;
			wait_cnt_r <= 16'h0000;
			low_cnt_r <= 16'h0000;
			low_sat_r <= 1'b0;
			rem_r <= 16'h0000;
			quo_r <= 16'h0000;
			len_r <= 16'h0000;
			load_cnt_r <= 16'h0000;
			tx_go_r <= 1'b0;
			branch_r <= 1'b0;
			ram_reserved <= 1'b1;
			boot_active_r <= 1'b1;
		end else begin
			tx_go_r <= 1'b0;
			branch_r <= 1'b0;
			if (wdt_overflow && state_r != fsb_pkg::ST_EXIT) begin
				state_r <= fsb_pkg::ST_EXIT;
				ram_reserved <= 1'b0;
				boot_active_r <= 1'b0;
			end else begin
				case (state_r)
					fsb_pkg::ST_RESET_WAIT: begin
						wait_cnt_r <= wait_cnt_r + 16'h0001;
						if (wait_cnt_r == 16'(fsb_pkg::BOOT_READY_CYC - 1)) begin
							state_r <= boot_mode ? fsb_pkg::ST_MEAS_IDLE : fsb_pkg::ST_EXIT;
							ram_reserved <= boot_mode;
							boot_active_r <= boot_mode;
						end
					end
					fsb_pkg::ST_MEAS_IDLE: begin
						low_cnt_r <= 16'h0000;
						low_sat_r <= 1'b0;
						if (!rxd) begin
							state_r <= fsb_pkg::ST_MEAS_LOW;
						end
					end
					fsb_pkg::ST_MEAS_LOW: begin
						// time the low period of a zero byte
						if (!rxd) begin
							if (low_cnt_r == 16'hFFFF) begin
								low_sat_r <= 1'b1;
							end else begin
								low_cnt_r <= low_cnt_r + 16'h0001;
							end
						end else if (low_sat_r || low_cnt_r < fsb_pkg::MIN_LOW_CYC) begin
							state_r <= fsb_pkg::ST_MEAS_IDLE;
						end else begin
							rem_r <= low_cnt_r + 16'h0001;
							quo_r <= 16'h0000;
							state_r <= fsb_pkg::ST_DIVIDE;
						end
					end
					fsb_pkg::ST_DIVIDE: begin
						// low period over nine bit times
						if (rem_r >= fsb_pkg::BITS_PER_LOW) begin
							rem_r <= rem_r - fsb_pkg::BITS_PER_LOW;
							quo_r <= quo_r + 16'h0001;
						end else if (quo_r < fsb_pkg::MIN_BIT_CYC) begin
							state_r <= fsb_pkg::ST_MEAS_IDLE;
						end else begin
							tx_go_r <= 1'b1;
							state_r <= fsb_pkg::ST_SEND_ACK;
						end
					end
					fsb_pkg::ST_SEND_ACK: begin
						// wait for the single zero byte to leave
						if (!tx_busy_r && !tx_go_r) begin
							state_r <= fsb_pkg::ST_WAIT_55;
						end
					end
					fsb_pkg::ST_WAIT_55: begin
						// stray zero bytes from the host are ignored
						if (rx_valid_r && rx_shift_r == fsb_pkg::ACK_BYTE) begin
							state_r <= fsb_pkg::ST_LEN_HI;
						end
					end
					fsb_pkg::ST_LEN_HI: begin
						if (rx_valid_r) begin
							len_r <= {rx_shift_r, 8'h00};
							state_r <= fsb_pkg::ST_LEN_LO;
						end
					end
					fsb_pkg::ST_LEN_LO: begin
						if (rx_valid_r) begin
							len_r <= len_nxt;
							load_cnt_r <= 16'h0000;
							state_r <= (len_nxt == 16'h0000) ? fsb_pkg::ST_BRANCH : fsb_pkg::ST_LOAD;
						end
					end
					fsb_pkg::ST_LOAD: begin
						if (rx_valid_r) begin
							load_cnt_r <= load_cnt_r + 16'h0001;
							if (load_cnt_r + 16'h0001 == len_r) begin
								state_r <= fsb_pkg::ST_BRANCH;
							end
						end
					end
					fsb_pkg::ST_BRANCH: begin
						// release the boot area at the branch
						ram_reserved <= 1'b0;
						branch_r <= 1'b1;
						boot_active_r <= 1'b0;
						state_r <= fsb_pkg::ST_EXIT;
					end
					fsb_pkg::ST_EXIT: begin
						state_r <= fsb_pkg::ST_EXIT;
					end
					default: begin
						state_r <= fsb_pkg::ST_EXIT;
						boot_active_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// bit rate setting
	// ----------------------------------------------------------------
	// adjusted value survives the branch for the loaded program
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			bit_rate_setting_reg <= fsb_pkg::RST_BRR;
		end else if (state_r == fsb_pkg::ST_DIVIDE && rem_r < fsb_pkg::BITS_PER_LOW) begin
			bit_rate_setting_reg <= quo_r;
		end else if (wr_fire && avl_req.address == fsb_pkg::REG_BRR && state_r == fsb_pkg::ST_EXIT) begin
			bit_rate_setting_reg <= avl_req.writedata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// transfer area
	// ----------------------------------------------------------------
	// index 0 stands for the area base address
	fsb_boot_ram #(
		.DEPTH(RAM_DEPTH),
		.AW(RAM_AW)
	) u_ram (
		.clk_sys(clk_sys),
		.wr_en(state_r == fsb_pkg::ST_LOAD && rx_valid_r),
		.wr_addr(load_cnt_r[RAM_AW-1:0]),
		.wr_data(rx_shift_r),
		.rd_addr(ram_raddr_r),
		.rd_data_r(ram_rdata)
	);

endmodule : fsb_top

// >>> verilog/fsb_pkg.sv
// fsb_pkg: constants, register map and types of the flash serial boot loader
package fsb_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int BOOT_READY_STATES = 100;
	localparam int BOOT_READY_NS = BOOT_READY_STATES * CLK_PERIOD_NS;
	localparam int BOOT_READY_CYC = (BOOT_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] BITS_PER_LOW = 16'h0009;
	localparam logic [15:0] MIN_BIT_CYC = 16'h0004;
	localparam logic [15:0] MIN_LOW_CYC = 16'h0024;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_PWR = 8'h00;
	localparam logic [7:0] REG_GATE = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_BRR = 8'h0C;
	localparam logic [7:0] REG_CNT = 8'h10;
	localparam logic [7:0] REG_RADDR = 8'h14;
	localparam logic [7:0] REG_RDATA = 8'h18;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int PWR_INHIBIT_POS = 7;
	localparam int GATE_ENABLE_POS = 7;
	localparam logic RST_INHIBIT = 1'b0;
	localparam logic RST_ENABLE = 1'b0;
	localparam logic [15:0] RST_BRR = 16'h0000;

	// ----------------------------------------------------------------
	// boot protocol
	// ----------------------------------------------------------------
	localparam logic [7:0] SYNC_BYTE = 8'h00;
	localparam logic [7:0] ACK_BYTE = 8'h55;
	localparam logic [15:0] AREA_BASE = 16'hF780;
	localparam logic [15:0] AREA_LAST = 16'hFEEF;
	localparam logic [15:0] AREA_SIZE = AREA_LAST - AREA_BASE + 16'h0001;

	typedef enum logic [3:0] {
		ST_RESET_WAIT = 4'h0,
		ST_MEAS_IDLE = 4'h1,
		ST_MEAS_LOW = 4'h2,
		ST_DIVIDE = 4'h3,
		ST_SEND_ACK = 4'h4,
		ST_WAIT_55 = 4'h5,
		ST_LEN_HI = 4'h6,
		ST_LEN_LO = 4'h7,
		ST_LOAD = 4'h8,
		ST_BRANCH = 4'h9,
		ST_EXIT = 4'hA
	} fsb_state_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} fsb_avl_req_t;

endpackage : fsb_pkg

// >>> verilog/fsb_boot_ram.sv
// fsb_boot_ram: transfer area memory, one write port, registered read port
`timescale 1ns/1ps
module fsb_boot_ram #(
	parameter int DEPTH = 1904,
	parameter int AW = 11
) (
	// clock
	input wire logic clk_sys,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	// read side
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data_r
);

	logic [7:0] mem [0:DEPTH-1];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		rd_data_r <= mem[rd_addr];
	end

endmodule : fsb_boot_ram

// >>> dv/fsb_top_properties.sv
// fsb_top_properties: port-level assertions for the boot loader
`timescale 1ns/1ps
module fsb_top_properties (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register bus
	input wire fsb_pkg::fsb_avl_req_t avl_req,
	input wire logic [31:0] avl_readdata,
	input wire logic avl_waitrequest,
	// serial link
	input wire logic rxd,
	input wire logic txd_o,
	input wire logic txd_oe,
	// system
	input wire logic boot_mode,
	input wire logic wdt_overflow,
	input wire logic subactive,
	input wire logic flash_powerdown,
	input wire logic boot_active,
	input wire logic ram_reserved,
	input wire logic branch_pulse
);
	logic [7:0] since_rst_r;
	logic flash_rd;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// saturates so a long run never wraps back into the wait window
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			since_rst_r <= 8'h00;
		else if (since_rst_r != 8'hFF)
			since_rst_r <= since_rst_r + 8'h01;
	end
	assign flash_rd = avl_req.read && !avl_waitrequest &&
		(avl_req.address == fsb_pkg::REG_PWR || avl_req.address == fsb_pkg::REG_GATE);
	pd_gate_a: assert property (!subactive |=> !flash_powerdown)
		else $error("flash powered down outside subactive");
	pad_zero_a: assert property (flash_rd |-> avl_readdata[31:8] == 24'h000000 && avl_readdata[6:0] == 7'h00)
		else $error("unused flash register bits read nonzero");
	bus_answer_a: assert property ((avl_req.read || avl_req.write) && avl_waitrequest |=> !avl_waitrequest)
		else $error("bus access not answered next cycle");
	bus_single_a: assert property (!avl_waitrequest |=> avl_waitrequest)
		else $error("waitrequest low for more than one cycle");
	ready_wait_a: assert property (since_rst_r < 8'h5A |-> !txd_oe && boot_active)
		else $error("boot started before the post-reset wait");
	wdt_exit_a: assert property (wdt_overflow && boot_active |=> !boot_active && !ram_reserved)
		else $error("watchdog overflow did not end boot");
	exit_stays_a: assert property (!boot_active |=> !boot_active)
		else $error("boot resumed without reset");
	branch_pin_a: assert property (branch_pulse |-> txd_o && txd_oe && !ram_reserved)
		else $error("transmit pin not driven high at branch");
	branch_exit_a: assert property (branch_pulse |=> !boot_active && !branch_pulse)
		else $error("boot still active after branch");
	reserve_hold_a: assert property ($fell(ram_reserved) |-> branch_pulse || !boot_active)
		else $error("boot area released before branch");
	cover property (branch_pulse);
	cover property (wdt_overflow && boot_active);
	cover property (flash_rd);
endmodule : fsb_top_properties

bind fsb_top fsb_top_properties fsb_top_properties_i (.clk_sys, .rst_b, .avl_req, .avl_readdata,
	.avl_waitrequest, .rxd, .txd_o, .txd_oe, .boot_mode, .wdt_overflow, .subactive, .flash_powerdown,
	.boot_active, .ram_reserved, .branch_pulse);

// >>> dv/fsb_host.sv
// fsb_host: serial host model that drives the boot link and decodes replies
`timescale 1ns/1ps
module fsb_host #(
	parameter int Q = 8
) (
	// clock
	input wire logic clk_sys,
	// device transmit pin
	input wire logic txd_o,
	input wire logic txd_oe,
	// device receive pin
	output logic rxd
);
	logic line;
	logic [7:0] rx_byte;
	int rx_count;
	// pulled up on the board while the device leaves the pin undriven
	assign line = txd_oe ? txd_o : 1'b1;
	initial begin
		rxd = 1'b1;
		rx_byte = 8'h00;
		rx_count = 0;
	end
	// start, eight data lsb first, one stop, no parity
	task automatic send_byte(input logic [7:0] b, input int q);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (q) @(posedge clk_sys);
		end
	endtask : send_byte
	// receiver samples mid bit at the matched rate
	initial begin
		forever begin
			@(posedge clk_sys);
			if (line === 1'b0) begin
				repeat (Q / 2) @(posedge clk_sys);
				for (int i = 0; i < 8; i++) begin
					repeat (Q) @(posedge clk_sys);
					rx_byte[i] = line;
				end
				repeat (Q) @(posedge clk_sys);
				rx_count++;
			end
		end
	end
endmodule : fsb_host

// >>> dv/fsb_top_tb.sv
// fsb_top_tb: self-checking bench for the flash serial boot loader
`timescale 1ns/1ps
module fsb_top_tb;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} fsb_row_t;
	localparam int Q = 8;
	localparam fsb_row_t ROWS [14] = '{
		'{1'b0, fsb_pkg::REG_GATE, 32'h0, 32'h0}, '{1'b0, fsb_pkg::REG_PWR, 32'h0, 32'h0},
		'{1'b1, fsb_pkg::REG_PWR, 32'h80, 32'h0}, '{1'b0, fsb_pkg::REG_PWR, 32'h0, 32'h0},
		'{1'b1, fsb_pkg::REG_GATE, 32'hFFFFFFFF, 32'h0}, '{1'b0, fsb_pkg::REG_GATE, 32'h0, 32'h80},
		'{1'b1, fsb_pkg::REG_PWR, 32'hFF, 32'h0}, '{1'b0, fsb_pkg::REG_PWR, 32'h0, 32'h80},
		'{1'b0, 8'h1C, 32'h0, 32'h0}, '{1'b1, fsb_pkg::REG_GATE, 32'h0, 32'h0},
		'{1'b0, fsb_pkg::REG_PWR, 32'h0, 32'h0}, '{1'b1, fsb_pkg::REG_PWR, 32'h0, 32'h0},
		'{1'b1, fsb_pkg::REG_GATE, 32'h80, 32'h0}, '{1'b0, fsb_pkg::REG_PWR, 32'h0, 32'h80}};
	logic clk_sys, rst_b, rxd, txd_o, txd_oe, boot_mode, wdt_overflow, subactive;
	logic flash_powerdown, boot_active, ram_reserved, branch_pulse, avl_waitrequest;
	fsb_pkg::fsb_avl_req_t avl_req;
	logic [31:0] avl_readdata, q;
	// program held by the host before boot, it sets up its own registers
	logic [7:0] prog [3] = '{8'hA1, 8'hB2, 8'hC3};
	int mismatches = 0;
	int cmp_count = 0;
	int n;
	fsb_top fsb_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .avl_req(avl_req), .avl_readdata(avl_readdata),
		.avl_waitrequest(avl_waitrequest), .rxd(rxd), .txd_o(txd_o), .txd_oe(txd_oe), .boot_mode(boot_mode),
		.wdt_overflow(wdt_overflow), .subactive(subactive), .flash_powerdown(flash_powerdown),
		.boot_active(boot_active), .ram_reserved(ram_reserved), .branch_pulse(branch_pulse));
	fsb_host #(.Q(Q)) fsb_host_i (.clk_sys(clk_sys), .txd_o(txd_o), .txd_oe(txd_oe), .rxd(rxd));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		avl_req <= '{read: !wr, write: wr, address: a, writedata: d};
		@(posedge clk_sys);
		// only the watchdog ends a wait that never gets an answer
		while (avl_waitrequest !== 1'b0)
			@(posedge clk_sys);
		rd = avl_readdata;
		avl_req <= '0;
		@(posedge clk_sys);
	endtask : bus
	task automatic do_reset(input int cyc);
		rst_b <= 1'b0;
		repeat (cyc) @(posedge clk_sys);
		rst_b <= 1'b1;
	endtask : do_reset
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		#2000000;
		mismatches++;
		complete_run();
	end
	initial begin
		rst_b = 1'b0;
		avl_req = '0;
		boot_mode = 1'b1;
		wdt_overflow = 1'b0;
		subactive = 1'b0;
		@(posedge clk_sys);
		do_reset(10);
		repeat (50) @(posedge clk_sys);
		check("early tx dir", txd_oe, 1'b0);
		foreach (ROWS[i]) begin
			bus(ROWS[i].wr, ROWS[i].a, ROWS[i].d, q);
			if (!ROWS[i].wr)
				check("register row", q, ROWS[i].e);
		end
		$display("test register rows done");
		bus(1'b1, fsb_pkg::REG_GATE, 32'h80, q);
		bus(1'b1, fsb_pkg::REG_PWR, 32'h80, q);
		subactive <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check("powerdown inhibited", flash_powerdown, 1'b0);
		bus(1'b1, fsb_pkg::REG_PWR, 32'h0, q);
		repeat (2) @(posedge clk_sys);
		check("powerdown active", flash_powerdown, 1'b1);
		subactive <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check("powerdown left", flash_powerdown, 1'b0);
		$display("test power control done");
		fsb_host_i.send_byte(8'h00, 2);
		repeat (100) @(posedge clk_sys);
		check("no ack on short low", fsb_host_i.rx_count, 32'h0);
		bus(1'b0, fsb_pkg::REG_STAT, 32'h0, q);
		check("remeasure", q[3:0], fsb_pkg::ST_MEAS_IDLE);
		for (n = 0; n < 40 && fsb_host_i.rx_count == 0; n++)
			fsb_host_i.send_byte(8'h00, Q);
		check("ack count", fsb_host_i.rx_count, 32'h1);
		check("ack value", fsb_host_i.rx_byte, 8'h00);
		// a zero byte overlapping the answer may be half taken; let it run out
		repeat (20 * Q) @(posedge clk_sys);
		bus(1'b0, fsb_pkg::REG_BRR, 32'h0, q);
		check("bit rate", q, Q);
		// refused while boot runs, seen by the bit rate kept check
		bus(1'b1, fsb_pkg::REG_BRR, 32'h21, q);
		fsb_host_i.send_byte(8'h55, Q);
		fsb_host_i.send_byte(8'h00, Q);
		fsb_host_i.send_byte(8'h03, Q);
		foreach (prog[i])
			fsb_host_i.send_byte(prog[i], Q);
		n = 0;
		while (branch_pulse !== 1'b1 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		check("branch seen", branch_pulse, 1'b1);
		repeat (2) @(posedge clk_sys);
		check("single ack", fsb_host_i.rx_count, 32'h1);
		bus(1'b0, fsb_pkg::REG_STAT, 32'h0, q);
		check("status at branch", q[9:5], 5'h0C);
		bus(1'b0, fsb_pkg::REG_CNT, 32'h0, q);
		check("load count", q, 32'h3);
		bus(1'b0, fsb_pkg::REG_BRR, 32'h0, q);
		check("bit rate kept", q, Q);
		foreach (prog[i]) begin
			bus(1'b1, fsb_pkg::REG_RADDR, i, q);
			repeat (2) @(posedge clk_sys);
			bus(1'b0, fsb_pkg::REG_RDATA, 32'h0, q);
			check("ram byte", q, prog[i]);
		end
		$display("test boot load done");
		// restart by long reset, strap levels unchanged
		do_reset(20);
		check("reset bus idle", avl_waitrequest, 1'b1);
		check("reset pin released", txd_oe, 1'b0);
		check("reset reserves ram", ram_reserved, 1'b1);
		repeat (120) @(posedge clk_sys);
		wdt_overflow <= 1'b1;
		@(posedge clk_sys);
		wdt_overflow <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check("wdt ends boot", boot_active, 1'b0);
		check("wdt frees ram", ram_reserved, 1'b0);
		$display("test watchdog exit done");
		// strap low: no boot, boot area free once the wait ends
		boot_mode <= 1'b0;
		do_reset(20);
		repeat (99) @(posedge clk_sys);
		check("strap wait", boot_active, 1'b1);
		repeat (2) @(posedge clk_sys);
		check("strap exit", boot_active, 1'b0);
		check("strap ram free", ram_reserved, 1'b0);
		check("strap pin idle", txd_oe, 1'b0);
		bus(1'b1, fsb_pkg::REG_BRR, 32'h21, q);
		bus(1'b0, fsb_pkg::REG_BRR, 32'h0, q);
		check("bit rate after boot", q, 32'h21);
		$display("test strap exit done");
		complete_run();
	end
endmodule : fsb_top_tb
